// ==== design/wsm_pkg.sv ====
// Contract
// RULE1: 9600 baud, 8 data, no parity, 1 stop
// RULE2: answer slave address 255 after reset
// RULE3: function 06 to address 00 sets address
// RULE4: address write reply echoes the request
// RULE5: function 03 to 00 returns address
// RULE6: host reads speed at register 0x0001
// RULE7: speed reply: address, 03, 02, value, CRC
// RULE8: CRC16 low first; drop bad frames silently
`default_nettype none
package wsm_pkg;
	// serial framing
	localparam int unsigned CLK_HZ    = 200_000_000;
	localparam int unsigned BAUD_BPS  = 9600;
	localparam int unsigned BIT_CYC   = CLK_HZ / BAUD_BPS;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BITS = 1;
	localparam int unsigned CHAR_BITS = 1 + DATA_BITS + STOP_BITS;
	// end of frame after 3.5 character times of silence
	localparam int unsigned GAP_BITS  = (CHAR_BITS * 7) / 2;

	// frame contents
	localparam logic [15:0] ADDR_RESET    = 16'h00FF;
	localparam logic [7:0]  ADDR_RESERVED = 8'h00;
	localparam logic [7:0]  FN_READ       = 8'h03;
	localparam logic [7:0]  FN_WRITE      = 8'h06;
	localparam logic [15:0] REG_ADDR      = 16'h0000;
	localparam logic [15:0] REG_SPEED     = 16'h0001;
	localparam logic [15:0] READ_COUNT    = 16'h0001;
	localparam logic [7:0]  BYTE_COUNT    = 8'h02;
	localparam logic [3:0]  REQ_LEN       = 4'h8;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY      = 16'hA001;

	// reflected modbus crc16, one byte
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction : crc16_byte
endpackage : wsm_pkg
`default_nettype wire

// ==== design/wsm_uart.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsm_uart #(
	parameter int unsigned BIT_CYCLES = wsm_pkg::BIT_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// line
	input  wire logic       rx_pin,
	output logic            tx_pin,
	// receive side
	output logic            rx_valid,
	output logic            rx_ferr,
	output logic [7:0]      rx_data,
	// transmit side
	input  wire logic       tx_start,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

	logic          s1_q, s2_q;
	logic          rx_act_q;
	logic [CW-1:0] rx_cnt_q;
	logic [3:0]    rx_bit_q;
	logic [7:0]    rx_sh_q;
	logic [CW-1:0] tx_cnt_q;
	logic [3:0]    tx_n_q;
	logic [9:0]    tx_sh_q;

	// two-stage synchroniser on the line input
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end
		else
		begin
			s1_q <= rx_pin;
			s2_q <= s1_q;
		end

	// receiver samples mid-bit, lsb first, one stop bit [RULE1]
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			rx_act_q <= 1'b0;
			rx_cnt_q <= '0;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			rx_valid <= 1'b0;
			rx_ferr  <= 1'b0;
			rx_data  <= 8'h00;
		end
		else
		begin
			rx_valid <= 1'b0;
			rx_ferr  <= 1'b0;
			if (!rx_act_q)
			begin
				if (!s2_q)
				begin
					rx_act_q <= 1'b1;
					rx_cnt_q <= HALF;
					rx_bit_q <= 4'h0;
				end
			end
			else if (rx_cnt_q != '0)
				rx_cnt_q <= rx_cnt_q - CW'(1);
			else
			begin
				rx_cnt_q <= FULL;
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && s2_q)
					rx_act_q <= 1'b0; // glitch, not a start bit
				else if (rx_bit_q == 4'h9)
				begin
					rx_act_q <= 1'b0;
					rx_valid <= s2_q;
					rx_ferr  <= !s2_q; // missing stop bit [RULE1]
					rx_data  <= rx_sh_q;
				end
				else if (rx_bit_q != 4'h0)
					rx_sh_q <= {s2_q, rx_sh_q[7:1]};
			end
		end

	// transmitter: start, 8 data lsb first, stop, no parity [RULE1]
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			tx_cnt_q <= '0;
			tx_n_q   <= 4'h0;
			tx_sh_q  <= 10'h3FF;
		end
		else if (tx_n_q == 4'h0)
		begin
			if (tx_start)
			begin
				tx_sh_q  <= {1'b1, tx_data, 1'b0};
				tx_n_q   <= 4'hA;
				tx_cnt_q <= FULL;
			end
		end
		else if (tx_cnt_q != '0)
			tx_cnt_q <= tx_cnt_q - CW'(1);
		else
		begin
			tx_cnt_q <= FULL;
			tx_n_q   <= tx_n_q - 4'h1;
			tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
		end

	assign tx_pin   = tx_sh_q[0];
	assign tx_ready = (tx_n_q == 4'h0);
endmodule : wsm_uart
`default_nettype wire

// ==== design/wsm_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsm_slave #(
	parameter int unsigned BIT_CYCLES = wsm_pkg::BIT_CYC,
	parameter int unsigned GAP_CYCLES = wsm_pkg::GAP_BITS * wsm_pkg::BIT_CYC
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	// rs485 transceiver
	input  wire logic        RXD,
	output logic             TXD,
	output logic             TXD_OE,
	// measurement in, address out
	input  wire logic [15:0] WIND_SPEED,
	output logic [15:0]      SLAVE_ADDR
);
	localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
	// reply lengths before the two crc bytes
	localparam logic [3:0]  ECHO_LEN = 4'h6;
	localparam logic [3:0]  READ_LEN = 4'h5;

	// gray coded along listen, reply, drain, release and back to listen
	typedef enum logic [1:0] {
		ST_LISTEN  = 2'b00,
		ST_REPLY   = 2'b01,
		ST_DRAIN   = 2'b11,
		ST_RELEASE = 2'b10
	} wsm_state_e;

	// sequencer and uart handshake
	wsm_state_e    state_q;
	logic          rx_valid;
	logic          rx_ferr;
	logic          tx_ready;
	logic          tx_start;
	logic [7:0]    rx_data;
	logic [7:0]    tx_data;
	// request and reply bytes
	logic [7:0]    req_q [0:7];
	logic [7:0]    rsp_q [0:5];
	logic [3:0]    nbytes_q;
	logic [3:0]    rlen_q;
	logic [3:0]    idx_q;
	logic          bad_q;
	// crc accumulators, address register and silence timer
	logic [15:0]   rx_crc_q;
	logic [15:0]   tx_crc_q;
	logic [15:0]   addr_q;
	logic [GW-1:0] gap_q;
	// decoded request
	logic          frame_end;
	logic [15:0]   f_reg;
	logic [15:0]   f_val;
	logic          f_ok;
	logic          is_wr_addr;
	logic          is_rd_addr;
	logic          is_rd_speed;

	// address, function and register fields against one accepted request kind
	function automatic logic hdr_is(
		input logic [7:0]  dev,
		input logic [7:0]  fn,
		input logic [15:0] reg_addr,
		input logic [7:0]  want_dev,
		input logic [7:0]  want_fn,
		input logic [15:0] want_reg
	);
		return (dev == want_dev) && (fn == want_fn) && (reg_addr == want_reg);
	endfunction : hdr_is

	wsm_uart #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_uart (
		.clk      (SYS_CLK),
		.rst_b    (RST_B),
		.rx_pin   (RXD),
		.tx_pin   (TXD),
		.rx_valid (rx_valid),
		.rx_ferr  (rx_ferr),
		.rx_data  (rx_data),
		.tx_start (tx_start),
		.tx_data  (tx_data),
		.tx_ready (tx_ready)
	);

	// silence timer; restarted by every character seen while listening
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
			gap_q <= '0;
		else if (state_q != ST_LISTEN || rx_valid || rx_ferr)
			gap_q <= '0;
		else if (gap_q != GW'(GAP_CYCLES))
			gap_q <= gap_q + GW'(1);

	// a character landing in the expiry cycle keeps the frame open instead of being lost
	assign frame_end = (state_q == ST_LISTEN) && (nbytes_q != 4'h0)
		&& (gap_q == GW'(GAP_CYCLES - 1)) && !rx_valid && !rx_ferr;

	// gather request bytes; own echo is ignored since the line is half duplex
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
		begin
			nbytes_q <= 4'h0;
			bad_q    <= 1'b0;
			rx_crc_q <= wsm_pkg::CRC_INIT;
		end
		else if (frame_end || state_q != ST_LISTEN)
		begin
			nbytes_q <= 4'h0;
			bad_q    <= 1'b0;
			rx_crc_q <= wsm_pkg::CRC_INIT;
		end
		else if (rx_ferr || (rx_valid && nbytes_q == wsm_pkg::REQ_LEN))
			bad_q <= 1'b1; // overlong or broken frames are dropped [RULE8]
		else if (rx_valid)
		begin
			nbytes_q <= nbytes_q + 4'h1;
			rx_crc_q <= wsm_pkg::crc16_byte(rx_crc_q, rx_data); // [RULE8]
		end

	// byte store, no reset needed as nbytes_q qualifies it
	always_ff @(posedge SYS_CLK)
		if (state_q == ST_LISTEN && rx_valid && nbytes_q < wsm_pkg::REQ_LEN)
			req_q[nbytes_q[2:0]] <= rx_data;

	// decode: crc over the whole frame including its crc leaves zero
	assign f_reg = {req_q[2], req_q[3]};
	assign f_val = {req_q[4], req_q[5]};
	assign f_ok  = (nbytes_q == wsm_pkg::REQ_LEN) && !bad_q
		&& (rx_crc_q == 16'h0000); // [RULE8]
	assign is_wr_addr = f_ok && hdr_is(req_q[0], req_q[1], f_reg,
		wsm_pkg::ADDR_RESERVED, wsm_pkg::FN_WRITE, wsm_pkg::REG_ADDR); // [RULE3]
	assign is_rd_addr = f_ok && hdr_is(req_q[0], req_q[1], f_reg,
		wsm_pkg::ADDR_RESERVED, wsm_pkg::FN_READ, wsm_pkg::REG_ADDR)
		&& f_val == wsm_pkg::READ_COUNT; // [RULE5]
	// only a one-byte address can appear on the wire, so a wider one never answers a speed read
	assign is_rd_speed = f_ok && hdr_is(req_q[0], req_q[1], f_reg,
		addr_q[7:0], wsm_pkg::FN_READ, wsm_pkg::REG_SPEED)
		&& addr_q[15:8] == 8'h00 && f_val == wsm_pkg::READ_COUNT; // [RULE6]

	// slave address register, default 255 until rewritten
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
			addr_q <= wsm_pkg::ADDR_RESET; // [RULE2]
		else if (frame_end && is_wr_addr)
			addr_q <= f_val; // [RULE3]

	// the register itself is the output, so a read back shows exactly what was stored
	assign SLAVE_ADDR = addr_q;

	// reply image, built once at frame end so the speed is a clean snapshot
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
		begin
			for (int i = 0; i < 6; i++)
				rsp_q[i] <= 8'h00;
			rlen_q <= 4'h0;
		end
		else if (frame_end)
		begin
			if (is_wr_addr)
			begin
				for (int i = 0; i < 6; i++)
					rsp_q[i] <= req_q[i]; // echo of the request [RULE4]
				rlen_q <= ECHO_LEN;
			end
			else
			begin
				rsp_q[0] <= is_rd_addr ? wsm_pkg::ADDR_RESERVED : addr_q[7:0];
				rsp_q[1] <= wsm_pkg::FN_READ; // [RULE5] [RULE7]
				rsp_q[2] <= wsm_pkg::BYTE_COUNT;
				rsp_q[3] <= is_rd_addr ? addr_q[15:8] : WIND_SPEED[15:8]; // [RULE7]
				rsp_q[4] <= is_rd_addr ? addr_q[7:0] : WIND_SPEED[7:0];
				rsp_q[5] <= 8'h00;
				rlen_q   <= READ_LEN;
			end
		end

	// sequencer; anything not decoded stays in listen, so no reply [RULE8]
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
			state_q <= ST_LISTEN;
		else
			case (state_q)
				ST_LISTEN:
					if (frame_end && (is_wr_addr || is_rd_addr || is_rd_speed))
						state_q <= ST_REPLY;
				ST_REPLY:
					if (tx_start && idx_q == rlen_q + 4'h1)
						state_q <= ST_DRAIN;
				ST_DRAIN:
					if (tx_ready)
						state_q <= ST_RELEASE; // last stop bit has run its full time
				ST_RELEASE:
					state_q <= ST_LISTEN; // spare cycle guards the stop bit against enable skew
				default:
					state_q <= ST_LISTEN;
			endcase

	// byte index and running crc of the reply
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
		begin
			idx_q    <= 4'h0;
			tx_crc_q <= wsm_pkg::CRC_INIT;
		end
		else if (state_q != ST_REPLY)
		begin
			idx_q    <= 4'h0;
			tx_crc_q <= wsm_pkg::CRC_INIT;
		end
		else if (tx_start)
		begin
			idx_q <= idx_q + 4'h1;
			if (idx_q < rlen_q)
				tx_crc_q <= wsm_pkg::crc16_byte(tx_crc_q, tx_data);
		end

	// payload, then crc low byte, then high byte [RULE8]
	// crc bytes come from the running sum, so the image is never walked twice
	assign tx_start = (state_q == ST_REPLY) && tx_ready;
	assign tx_data  = (idx_q < rlen_q) ? rsp_q[idx_q[2:0]]
		: (idx_q == rlen_q) ? tx_crc_q[7:0] : tx_crc_q[15:8];
	assign TXD_OE   = (state_q != ST_LISTEN);
endmodule : wsm_slave
`default_nettype wire

// ==== verification/wsm_slave_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsm_slave_chk #(
	parameter int unsigned BIT_CYCLES = 16,
	parameter int unsigned GAP_CYCLES = 560
) (
	// clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	// line and registers
	input wire logic        RXD,
	input wire logic        TXD,
	input wire logic        TXD_OE,
	input wire logic [15:0] WIND_SPEED,
	input wire logic [15:0] SLAVE_ADDR
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	logic [31:0] quiet_q;
	logic [31:0] oe_q;
	// idle time of the request line; saturates so long runs never wrap
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
			quiet_q <= 32'h0;
		else if (!RXD)
			quiet_q <= 32'h0;
		else if (~&quiet_q)
			quiet_q <= quiet_q + 32'h1;
	// length of the current reply
	always_ff @(posedge SYS_CLK or negedge RST_B)
		if (!RST_B)
			oe_q <= 32'h0;
		else
			oe_q <= TXD_OE ? oe_q + 32'h1 : 32'h0;
	property p_idle; !TXD_OE |-> TXD; endproperty
	a_idle: assert property (p_idle) else $error("line not idle high");
	property p_start; $rose(TXD_OE) |=> !TXD [*8]; endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_stop; $fell(TXD_OE) |-> TXD && $past(TXD); endproperty
	a_stop: assert property (p_stop) else $error("no stop bit");
	property p_rst_addr; $rose(RST_B) |-> SLAVE_ADDR == 16'h00FF; endproperty
	a_rst_addr: assert property (p_rst_addr) else $error("bad reset address");
	property p_set_echo; $changed(SLAVE_ADDR) |-> ##[0:3] TXD_OE; endproperty
	a_set_echo: assert property (p_set_echo) else $error("no echo");
	property p_set_idle; $changed(SLAVE_ADDR) |-> $past(!TXD_OE); endproperty
	a_set_idle: assert property (p_set_idle) else $error("address set mid reply");
	property p_gap; $rose(TXD_OE) |-> quiet_q >= GAP_CYCLES; endproperty
	a_gap: assert property (p_gap) else $error("reply before frame end");
	// each character costs one load cycle beyond its ten bits, plus two cycles of turn-off
	property p_len;
		$fell(TXD_OE) |-> oe_q == 7 * (10 * BIT_CYCLES + 1) + 2
			|| oe_q == 8 * (10 * BIT_CYCLES + 1) + 2;
	endproperty
	a_len: assert property (p_len) else $error("reply length");
endmodule : wsm_slave_chk
bind wsm_slave wsm_slave_chk #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES)) chk (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B), .RXD(RXD), .TXD(TXD), .TXD_OE(TXD_OE),
	.WIND_SPEED(WIND_SPEED), .SLAVE_ADDR(SLAVE_ADDR));
`default_nettype wire

// ==== verification/wsm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsm_host #(
	parameter int BC = 16
) (
	input  wire logic clk,
	input  wire logic line_in,
	output var logic  line_out
);
	// biased line rests high between characters
	initial line_out = 1'b1;
	// start, eight data lsb first, one stop, no parity
	task automatic put(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_out = f[i];
			repeat (BC) @(negedge clk);
		end
	endtask : put
	// bounded hunt for a start bit, then mid-bit sampling; ok low on timeout
	task automatic get(input int lim, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		repeat (BC / 2) @(negedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BC) @(negedge clk);
			b[i] = line_in;
		end
		repeat (BC) @(negedge clk);
		ok = n < lim && line_in === 1'b1;
	endtask : get
endmodule : wsm_host
`default_nettype wire

// ==== verification/tb_wsm_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_wsm_slave;
	localparam int BC = 16;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        rxd;
	logic        txd;
	logic        txd_oe;
	logic [15:0] wind_speed = 16'h0000;
	logic [15:0] slave_addr;
	int          bad_count = 0;
	int          comparisons = 0;
	int          m_addr = 255;
	int          a;
	always #2.5 sys_clk = ~sys_clk;
	wsm_slave #(.BIT_CYCLES(BC), .GAP_CYCLES(35 * BC)) DUT (.SYS_CLK(sys_clk), .RST_B(rst_b),
		.RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .WIND_SPEED(wind_speed), .SLAVE_ADDR(slave_addr));
	// a released driver leaves the biased line high, so the host must not see txd then
	wsm_host #(.BC(BC)) host (.clk(sys_clk), .line_in(txd_oe ? txd : 1'b1), .line_out(rxd));
	// reflected crc16, written apart from the design's own
	function automatic int crc(input int q[$]);
		int c;
		c = 16'hFFFF;
		foreach (q[i])
		begin
			c ^= q[i];
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	// one request, the expected reply from the model, then a quiet window
	task automatic xfer(input int a, f, r, v, bad);
		int q[$];
		int e[$];
		int c;
		logic [7:0] b;
		logic ok;
		wind_speed = 16'($urandom);
		q = {a, f, 0, r, 0, v};
		if (a == 0 && f == 6 && r == 0 && !bad)
		begin
			e = q;
			m_addr = v;
		end
		else if (a == 0 && f == 3 && r == 0 && v == 1 && !bad)
			e = {0, 3, 2, 0, m_addr};
		else if (a == m_addr && f == 3 && r == 1 && v == 1 && !bad)
			e = {a, 3, 2, wind_speed[15:8], wind_speed[7:0]};
		c = crc(q) ^ bad;
		q.push_back(c & 255);
		q.push_back(c >> 8);
		c = crc(e);
		e.push_back(c & 255);
		e.push_back(c >> 8);
		if (e.size() == 2)
			e.delete();
		// uneven pacing between characters, well inside the frame gap
		foreach (q[i])
		begin
			host.put(8'(q[i]));
			repeat ($urandom_range(40)) @(negedge sys_clk);
		end
		foreach (e[i])
		begin
			host.get(2000, b, ok);
			if (!ok)
			begin
				bad_count++;
				complete_run();
			end
			cmp("reply byte", 16'(e[i]), {8'h00, b});
		end
		c = 0;
		repeat (700) @(negedge sys_clk) c += txd_oe === 1'b1;
		cmp("silence", 16'h0000, {15'h0000, c > 12});
		$display("test done fn %0d addr %0d", f, a);
	endtask : xfer
	initial
	begin
		void'($urandom(86469));
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge sys_clk);
		cmp("address", 16'h00FF, slave_addr);
		xfer(0, 3, 0, 1, 0);
		xfer(255, 3, 1, 1, 0);
		xfer(255, 3, 1, 1, 1);
		for (int i = 0; i < 3; i++)
		begin
			a = $urandom_range(247, 1);
			xfer(0, 6, 0, a, 0);
			cmp("address", 16'(a), slave_addr);
			xfer(0, 3, 0, 1, 0);
			xfer(a, 3, 1, 1, 0);
			xfer(255, 3, 1, 1, 0);
		end
		// reset in mid-run must bring back the default address
		@(negedge sys_clk) rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		m_addr = 255;
		repeat (2) @(negedge sys_clk);
		cmp("address", 16'h00FF, slave_addr);
		xfer(255, 3, 1, 1, 0);
		complete_run();
	end
endmodule : tb_wsm_slave
`default_nettype wire
